// [common/regbank_consts.vh]
// Constants for the converter control and status register bank
`ifndef REGBANK_CONSTS_VH
`define REGBANK_CONSTS_VH

// Register offsets, eight-bit offset field
`define OFS_CONTROL 8'h01
`define OFS_FLAGS 8'h02
`define OFS_IDENTITY 8'h03
`define OFS_VCODE_A 8'h04
`define OFS_VCODE_B 8'h05

// Control register field positions
`define CTL_RANGE 6
`define CTL_ENABLE 5
`define CTL_FORCED 3
`define CTL_RAMP 2
`define CTL_SLEW_HI 1
`define CTL_SLEW_LO 0

// Event flag register field positions
`define FLG_THERMAL 1
`define FLG_POWER 0

// Identity register field positions
`define ID_MAKER_HI 7
`define ID_MAKER_LO 4
`define ID_MAJOR_HI 3
`define ID_MAJOR_LO 2
`define ID_MINOR_HI 1
`define ID_MINOR_LO 0

// Reset contents
`define RST_CONTROL 8'h00
`define RST_FLAGS 2'h0
`define RST_VCODE_A 7'h3c
`define RST_VCODE_B 7'h42
`define RST_MAJOR 2'h1
`define RST_MINOR 2'h0

// Output target arithmetic in millivolts
`define MV_LOW_BASE 13'h0708
`define MV_HIGH_BASE 13'h07e9
`define MV_STEP 13'h0019

// Serial framing
`define BITS_LAST 3'h7
`define READ_BIT 0

`endif

// [core/converter_regbank.v]
// Serial-bus reached control and status register bank of a buck-boost converter
//
// Overview of operation
// - Enable low or lockout restores reset contents
// - Control bit 6 picks low or high range
// - Control bit 5 enables converter, variant reset
// - Control bit 3 forced modulation, resets zero
// - Control bit 2 ramp modulation, resets zero
// - Control bits 1-0 slew code, reset 00
// - Reading flag register requests clearing its flags
// - Thermal flag latches, clears if condition gone
// - Power flag latches, clears if condition gone
// - Identity register read-only: maker, major, minor
// - Select low uses code A for target
// - Select high uses code B, same scale
`include "regbank_consts.vh"

module converter_regbank #(
  parameter [6:0] DEV_ADDR = 7'h5a, // Bus address, arbitrary value
  parameter ENABLE_AT_POWERUP = 1'b1, // Variant choice of enable reset
  parameter [3:0] MAKER_CODE = 4'h9, // Maker code, arbitrary value
  parameter [1:0] MAJOR_REV = `RST_MAJOR, // Major die revision
  parameter [1:0] MINOR_REV = `RST_MINOR // Minor die revision
) (
  input wire i_ref_clk, // 200 MHz system clock
  input wire i_reset, // Asynchronous reset, active high
  input wire i_scl, // Serial clock pin
  input wire i_sda, // Serial data pin, input side
  output wire o_sda_out, // Serial data output, always low
  output wire o_sda_oe, // Serial data pull-low enable
  input wire i_enable_pin, // Device enable pin, low clears registers
  input wire i_undervoltage_lockout, // Input supply under lockout threshold
  input wire i_output_voltage_select_pin, // Selects code A (low) or B (high)
  input wire i_thermal_event, // Overtemperature comparator
  input wire i_power_not_good, // Power-not-good comparator
  output wire o_converter_enable, // Power stage enable
  output wire o_high_range, // Output range select
  output wire o_forced_modulation_mode, // Forced modulation mode
  output wire o_ramp_modulation_mode, // Ramp modulation mode
  output wire [1:0] o_slew_code, // Slew rate code
  output reg [6:0] o_voltage_code, // Selected voltage code
  output reg [12:0] o_target_mv, // Selected target in millivolts
  output wire o_thermal_shutdown_flag, // Sticky thermal flag
  output wire o_power_good_flag // Sticky power-not-good flag
);

  // Serial engine states
  localparam [2:0] ST_IDLE = 3'h0; // Waiting for start
  localparam [2:0] ST_RX = 3'h1; // Receiving a byte
  localparam [2:0] ST_ACK = 3'h2; // Driving acknowledge
  localparam [2:0] ST_TX = 3'h3; // Sending a byte
  localparam [2:0] ST_MACK = 3'h4; // Host acknowledge slot
  // Receive phases
  localparam [1:0] PH_ADDR = 2'h0; // Device address byte
  localparam [1:0] PH_OFS = 2'h1; // Register offset byte
  localparam [1:0] PH_DATA = 2'h2; // Write data bytes

  wire [6:0] pins; // Synchronised pin levels
  wire scl_s = pins[0]; // Serial clock level
  wire sda_s = pins[1]; // Serial data level
  wire clear_s = ~pins[2] | pins[3]; // Volatile contents are lost
  wire output_voltage_select_pin_s = pins[4]; // Voltage select level
  wire therm_s = pins[5]; // Overtemperature present
  wire pngood_s = pins[6]; // Power-not-good present

  reg scl_prev_ff; // Serial clock one cycle ago
  reg sda_prev_ff; // Serial data one cycle ago
  reg [2:0] state_ff, nxt_state; // Engine state
  reg [1:0] phase_ff, nxt_phase; // Receive phase
  reg [2:0] cnt_ff, nxt_cnt; // Bit counter
  reg [7:0] shift_ff, nxt_shift; // Byte shifter
  reg [7:0] ofs_ff, nxt_ofs; // Register pointer
  reg read_ff, nxt_read; // Transfer direction after ack
  reg ack_on_ff, nxt_ack_on; // Acknowledge currently driven
  reg mack_ff, nxt_mack; // Host acknowledged last byte
  reg oe_ff, nxt_oe; // Data pull-low enable
  reg [7:0] ctrl_ff; // Control register
  reg [1:0] flags_ff; // Sticky event flags
  reg [6:0] code_a_ff; // Voltage code A
  reg [6:0] code_b_ff; // Voltage code B
  reg wr_stb; // Write strobe for the current byte
  reg rd_stb; // A register byte is loaded for sending

  // Start, stop and clock edges from the filtered pins
  wire start_ev = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  wire stop_ev = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  wire rise_ev = scl_s & ~scl_prev_ff;
  wire fall_ev = ~scl_s & scl_prev_ff;

  // Register read mux; unmapped offsets read zero
  // Contents come in as arguments so every register is in the caller's sensitivity
  function [7:0] reg_read;
    input [7:0] ofs;
    input [7:0] ctrl;
    input [1:0] flags;
    input [6:0] code_a;
    input [6:0] code_b;
    begin
      case (ofs)
        `OFS_CONTROL: reg_read = ctrl;
        `OFS_FLAGS: reg_read = {6'h00, flags};
        `OFS_IDENTITY: reg_read = {MAKER_CODE, MAJOR_REV, MINOR_REV};
        `OFS_VCODE_A: reg_read = {1'b0, code_a};
        `OFS_VCODE_B: reg_read = {1'b0, code_b};
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // Byte at the register pointer, ready for loading into the shifter
  wire [7:0] rd_byte = reg_read(ofs_ff, ctrl_ff, flags_ff, code_a_ff, code_b_ff);

  // Target in millivolts: range base plus code times step
  function [12:0] target_mv;
    input high;
    input [6:0] code;
    begin
      target_mv = (high ? `MV_HIGH_BASE : `MV_LOW_BASE) + {6'h00, code} * `MV_STEP;
    end
  endfunction

  // Synchronise every asynchronous pin; bus pins idle high
  pin_sync #(
    .WIDTH(7),
    .RST_VAL(7'h07)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_async({i_power_not_good, i_thermal_event, i_output_voltage_select_pin,
              i_undervoltage_lockout, i_enable_pin, i_sda, i_scl}),
    .o_level(pins)
  );

  // Serial engine next state
  always @* begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_ofs = ofs_ff;
    nxt_read = read_ff;
    nxt_ack_on = ack_on_ff;
    nxt_mack = mack_ff;
    nxt_oe = oe_ff;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    if (start_ev) begin
      // Start or repeated start: new address byte
      nxt_state = ST_RX;
      nxt_phase = PH_ADDR;
      nxt_cnt = 3'h0;
      nxt_oe = 1'b0;
    end else if (stop_ev) begin
      nxt_state = ST_IDLE;
      nxt_oe = 1'b0;
    end else begin
      case (state_ff)
        ST_RX: begin
          if (rise_ev) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == `BITS_LAST) begin
              nxt_state = ST_ACK;
              nxt_ack_on = 1'b0;
              nxt_read = 1'b0;
              // Address, then offset, then data bytes
              case (phase_ff)
                PH_ADDR: begin
                  if (shift_ff[6:0] != DEV_ADDR) begin
                    nxt_state = ST_IDLE;
                  end else begin
                    nxt_read = sda_s;
                    nxt_phase = PH_OFS;
                  end
                end
                PH_OFS: begin
                  nxt_ofs = {shift_ff[6:0], sda_s};
                  nxt_phase = PH_DATA;
                end
                default: begin
                  wr_stb = 1'b1;
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (fall_ev) begin
            if (!ack_on_ff) begin
              nxt_ack_on = 1'b1;
              nxt_oe = 1'b1;
            end else if (read_ff) begin
              // Load first byte and drive its top bit
              rd_stb = 1'b1;
              nxt_shift = rd_byte;
              nxt_ofs = ofs_ff + 8'h01;
              nxt_oe = ~rd_byte[7];
              nxt_cnt = 3'h0;
              nxt_state = ST_TX;
            end else begin
              nxt_oe = 1'b0;
              nxt_cnt = 3'h0;
              nxt_state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (fall_ev) begin
            if (cnt_ff == `BITS_LAST) begin
              nxt_oe = 1'b0;
              nxt_mack = 1'b0;
              nxt_state = ST_MACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_oe = ~shift_ff[6];
              nxt_cnt = cnt_ff + 3'h1;
            end
          end
        end
        ST_MACK: begin
          if (rise_ev) begin
            nxt_mack = ~sda_s;
          end else if (fall_ev) begin
            if (mack_ff) begin
              rd_stb = 1'b1;
              nxt_shift = rd_byte;
              nxt_ofs = ofs_ff + 8'h01;
              nxt_oe = ~rd_byte[7];
              nxt_cnt = 3'h0;
              nxt_state = ST_TX;
            end else begin
              // Host refused further data
              nxt_state = ST_IDLE;
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  // Serial engine registers
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      state_ff <= ST_IDLE;
      phase_ff <= PH_ADDR;
      cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      ofs_ff <= 8'h00;
      read_ff <= 1'b0;
      ack_on_ff <= 1'b0;
      mack_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      ofs_ff <= nxt_ofs;
      read_ff <= nxt_read;
      ack_on_ff <= nxt_ack_on;
      mack_ff <= nxt_mack;
      oe_ff <= nxt_oe;
    end
  end

  // Register writes; byte taken at its eighth clock rise
  wire [7:0] wr_data = {shift_ff[6:0], sda_s};
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_ff <= `RST_CONTROL | ({7'h00, ENABLE_AT_POWERUP} << `CTL_ENABLE);
      code_a_ff <= `RST_VCODE_A;
      code_b_ff <= `RST_VCODE_B;
    // Volatile contents lost, clear beats writes
    end else if (clear_s) begin
      ctrl_ff <= `RST_CONTROL | ({7'h00, ENABLE_AT_POWERUP} << `CTL_ENABLE);
      code_a_ff <= `RST_VCODE_A;
      code_b_ff <= `RST_VCODE_B;
    end else if (wr_stb) begin
      // Other offsets and read-only ones ignore writes
      case (ofs_ff)
        // Reserved bits stored as the host writes them
        `OFS_CONTROL: ctrl_ff <= wr_data;
        `OFS_VCODE_A: code_a_ff <= wr_data[6:0];
        `OFS_VCODE_B: code_b_ff <= wr_data[6:0];
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // Sticky flags: a present condition sets, so set wins over the read clear
  wire flag_rd = rd_stb & (ofs_ff == `OFS_FLAGS);
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      flags_ff <= `RST_FLAGS;
    end else if (clear_s) begin
      flags_ff <= `RST_FLAGS;
    end else begin
      flags_ff[`FLG_THERMAL] <= therm_s | (flags_ff[`FLG_THERMAL] & ~flag_rd);
      flags_ff[`FLG_POWER] <= pngood_s | (flags_ff[`FLG_POWER] & ~flag_rd);
    end
  end

  // Selected code and target, registered
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_voltage_code <= `RST_VCODE_A;
      o_target_mv <= 13'h0000;
    end else begin
      o_voltage_code <= output_voltage_select_pin_s ? code_b_ff : code_a_ff;
      o_target_mv <= target_mv(ctrl_ff[`CTL_RANGE], output_voltage_select_pin_s ? code_b_ff : code_a_ff);
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = oe_ff;
  assign o_high_range = ctrl_ff[`CTL_RANGE];
  assign o_converter_enable = ctrl_ff[`CTL_ENABLE];
  assign o_forced_modulation_mode = ctrl_ff[`CTL_FORCED];
  assign o_ramp_modulation_mode = ctrl_ff[`CTL_RAMP];
  assign o_slew_code = ctrl_ff[`CTL_SLEW_HI:`CTL_SLEW_LO];
  assign o_thermal_shutdown_flag = flags_ff[`FLG_THERMAL];
  assign o_power_good_flag = flags_ff[`FLG_POWER];

endmodule // converter_regbank

// [core/pin_sync.v]
// Three-stage input synchroniser with agreement filter for asynchronous pins
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire i_ref_clk, // System clock
  input wire i_reset, // Asynchronous reset, active high
  input wire [WIDTH-1:0] i_async, // Pins from outside the clock domain
  output reg [WIDTH-1:0] o_level // Filtered level
);

  reg [WIDTH-1:0] meta_ff; // First stage, read only by the second
  reg [WIDTH-1:0] stage2_ff; // Second stage
  reg [WIDTH-1:0] stage3_ff; // Third stage
  reg [WIDTH-1:0] nxt_level; // Next filtered level
  integer k; // Bit index

  // Accept a change only once stages two and three agree
  always @* begin
    nxt_level = o_level;
    for (k = 0; k < WIDTH; k = k + 1) begin
      if (stage2_ff[k] == stage3_ff[k]) begin
        nxt_level[k] = stage3_ff[k];
      end
    end
  end

  // Shift chain; reset to the idle level of each pin
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_ff <= RST_VAL;
      stage2_ff <= RST_VAL;
      stage3_ff <= RST_VAL;
      o_level <= RST_VAL;
    end else begin
      meta_ff <= i_async;
      stage2_ff <= meta_ff;
      stage3_ff <= stage2_ff;
      o_level <= nxt_level;
    end
  end

endmodule // pin_sync

// [dv/converter_regbank_assertions.sv]
// Port-level concurrent checks for the converter register bank
module converter_regbank_assertions #(
  parameter logic ENABLE_AT_POWERUP = 1'b1 // Variant enable reset
) (
  input logic i_ref_clk, // Clock
  input logic i_reset, // Reset
  input logic i_scl, // Bus clock
  input logic i_sda, // Bus data
  input logic o_sda_out, // Data value
  input logic o_sda_oe, // Data enable
  input logic i_enable_pin, // Enable pin
  input logic i_undervoltage_lockout, // Lockout
  input logic i_output_voltage_select_pin, // Select
  input logic i_thermal_event, // Heat
  input logic i_power_not_good, // Power bad
  input logic o_converter_enable, // Enable
  input logic o_high_range, // Range
  input logic o_forced_modulation_mode, // Forced
  input logic o_ramp_modulation_mode, // Ramp
  input logic [1:0] o_slew_code, // Slew
  input logic [6:0] o_voltage_code, // Code
  input logic [12:0] o_target_mv, // Target
  input logic o_thermal_shutdown_flag, // Heat flag
  input logic o_power_good_flag // Power flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  logic [1:0] stab_ff; // Cycles code and range held
  logic [7:0] heat_ff; // Recent heat samples
  logic [7:0] pwr_ff; // Recent power samples
  // Histories trace a flag rise to its cause across the sync lag
  // Target is registered, so it follows the combinational range one cycle late
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      stab_ff <= 2'h0;
      heat_ff <= 8'h00;
      pwr_ff <= 8'h00;
    end else begin
      heat_ff <= {heat_ff[6:0], i_thermal_event};
      pwr_ff <= {pwr_ff[6:0], i_power_not_good};
      if (!$stable(o_voltage_code) || !$stable(o_high_range)) begin
        stab_ff <= 2'h0;
      end else if (stab_ff != 2'h3) begin
        stab_ff <= stab_ff + 2'h1;
      end
    end
  end
  property p_sda_low;
    o_sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data value not low");
  property p_target;
    stab_ff == 2'h3 |-> o_target_mv ==
      ($past(o_high_range) ? 13'h07e9 : 13'h0708) + 13'h0019 * {6'h00, o_voltage_code};
  endproperty
  a_target: assert property (p_target) else $error("target mismatch");
  property p_clr_ctl;
    (!i_enable_pin) [*7] |=> {o_high_range, o_forced_modulation_mode,
      o_ramp_modulation_mode, o_slew_code} == 5'h00 && o_converter_enable == ENABLE_AT_POWERUP;
  endproperty
  a_clr_ctl: assert property (p_clr_ctl) else $error("control not cleared");
  property p_clr_code;
    (i_undervoltage_lockout && !i_output_voltage_select_pin) [*7] |=> o_voltage_code == 7'h3c;
  endproperty
  a_clr_code: assert property (p_clr_code) else $error("code not cleared");
  property p_heat_hold;
    i_thermal_event [*7] |-> o_thermal_shutdown_flag;
  endproperty
  a_heat_hold: assert property (p_heat_hold) else $error("heat flag low");
  property p_pwr_hold;
    i_power_not_good [*7] |-> o_power_good_flag;
  endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("power flag low");
  property p_heat_cause;
    $rose(o_thermal_shutdown_flag) |-> heat_ff != 8'h00;
  endproperty
  a_heat_cause: assert property (p_heat_cause) else $error("heat flag uncaused");
  property p_pwr_cause;
    $rose(o_power_good_flag) |-> pwr_ff != 8'h00;
  endproperty
  a_pwr_cause: assert property (p_pwr_cause) else $error("power flag uncaused");
endmodule // converter_regbank_assertions

// [dv/converter_regbank_tb.sv]
// Self-checking bench for the converter register bank
module converter_regbank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, reset = 1, en_pin = 1, lockout = 0, sel_pin = 0;
  logic heat = 0, pwr_bad = 0, sda_oe, conv_en, rng, forced, ramp;
  logic heat_flag, pwr_flag;
  logic [1:0] slew;
  logic [6:0] vcode;
  logic [12:0] target;
  wire scl, host_sda, sda_out;
  wire sda = host_sda & ~sda_oe; // Pull-up line
  int num_errors = 0;
  int num_checks = 0;
  serial_host_model serial_host_model_inst (.i_ref_clk(ref_clk), .i_sda(sda),
    .o_scl(scl), .o_sda(host_sda));
  converter_regbank converter_regbank_inst (.i_ref_clk(ref_clk), .i_reset(reset),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_enable_pin(en_pin), .i_undervoltage_lockout(lockout),
    .i_output_voltage_select_pin(sel_pin), .i_thermal_event(heat),
    .i_power_not_good(pwr_bad), .o_converter_enable(conv_en), .o_high_range(rng),
    .o_forced_modulation_mode(forced), .o_ramp_modulation_mode(ramp),
    .o_slew_code(slew), .o_voltage_code(vcode), .o_target_mv(target),
    .o_thermal_shutdown_flag(heat_flag), .o_power_good_flag(pwr_flag));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic [12:0] e, input logic [12:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    serial_host_model_inst.wr(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    serial_host_model_inst.rd(a, d);
    chk_reg($sformatf("reg %h", a), e, d);
  endtask
  // Expected code and millivolt target
  task automatic out_chk(input logic hi, input logic [6:0] c);
    chk_pin("code", {6'h00, c}, {6'h00, vcode});
    chk_pin("target", (hi ? 13'h07e9 : 13'h0708) + 13'h0019 * {6'h00, c}, target);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Cut a hung bus transfer short
  initial begin
    #200000;
    num_errors++;
    $display("ERROR watchdog expected done seen hang");
    final_report;
  end
  initial begin
    logic [7:0] c;
    wt(4);
    reset = 1'b0;
    wt(8);
    rd_chk(8'h01, 8'h20);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h94);
    rd_chk(8'h04, 8'h3c);
    rd_chk(8'h05, 8'h42);
    rd_chk(8'h06, 8'h00);
    out_chk(1'b0, 7'h3c);
    wr(8'h03, 8'h00);
    rd_chk(8'h03, 8'h94);
    for (int i = 0; i < 4; i++) begin
      c = {1'b0, i[0], ~i[0], 1'b0, i[1], ~i[1], i[1:0]};
      wr(8'h01, c);
      rd_chk(8'h01, c);
      chk_pin("ctl", {7'h00, c[6:5], c[3:0]}, {7'h00, rng, conv_en, forced, ramp, slew});
    end
    wr(8'h04, 8'hff);
    rd_chk(8'h04, 8'h7f);
    out_chk(1'b1, 7'h7f);
    wr(8'h05, 8'h00);
    sel_pin = 1'b1;
    wt(10);
    out_chk(1'b1, 7'h00);
    wr(8'h01, 8'h00);
    out_chk(1'b0, 7'h00);
    sel_pin = 1'b0;
    wt(10);
    out_chk(1'b0, 7'h7f);
    heat = 1'b1;
    pwr_bad = 1'b1;
    wt(10);
    chk_pin("flags", 13'h0003, {11'h000, heat_flag, pwr_flag});
    heat = 1'b0;
    wt(10);
    rd_chk(8'h02, 8'h03);
    rd_chk(8'h02, 8'h01);
    pwr_bad = 1'b0;
    wt(10);
    rd_chk(8'h02, 8'h01);
    rd_chk(8'h02, 8'h00);
    chk_pin("flags", 13'h0000, {11'h000, heat_flag, pwr_flag});
    for (int j = 0; j < 2; j++) begin
      wr(8'h01, 8'h0c);
      wr(8'h04, 8'h11);
      en_pin = j[0];
      lockout = j[0];
      wt(10);
      en_pin = 1'b1;
      lockout = 1'b0;
      wt(10);
      rd_chk(8'h01, 8'h20);
      rd_chk(8'h04, 8'h3c);
    end
    chk_pin("nacks", 13'h0000, serial_host_model_inst.nacks[12:0]);
    final_report;
  end
endmodule // converter_regbank_tb
bind converter_regbank converter_regbank_assertions #(
  .ENABLE_AT_POWERUP(ENABLE_AT_POWERUP)) converter_regbank_assertions_inst (.*);

// [dv/serial_host_model.sv]
// Open-drain serial bus host model
module serial_host_model #(
  parameter logic [6:0] BUS_ADDR = 7'h5a // Device address
) (
  input logic i_ref_clk, // Edge alignment
  input logic i_sda, // Resolved data line
  output logic o_scl, // Clock, idles high
  output logic o_sda // Drive, one releases
);
  timeunit 1ns;
  timeprecision 100ps;
  int nacks = 0; // Missing acknowledges
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic bit_io(input logic b, output logic s);
    o_sda = b;
    #20 o_scl = 1'b1;
    #20 s = i_sda;
    #20 o_scl = 1'b0;
    #20;
  endtask
  // Start or repeated start, edge aligned
  task automatic start;
    @(posedge i_ref_clk);
    #1 o_sda = 1'b1;
    #20 o_scl = 1'b1;
    #20 o_sda = 1'b0;
    #20 o_scl = 1'b0;
    #20;
  endtask
  task automatic stop;
    o_sda = 1'b0;
    #20 o_scl = 1'b1;
    #20 o_sda = 1'b1;
    #20;
  endtask
  task automatic tx(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    if (s !== 1'b0) nacks++;
  endtask
  task automatic rx(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    // Host refuses more bytes
    bit_io(1'b1, s);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
    start;
    tx({BUS_ADDR, 1'b0});
    tx(ofs);
    tx(dat);
    stop;
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] dat);
    start;
    tx({BUS_ADDR, 1'b0});
    tx(ofs);
    start;
    tx({BUS_ADDR, 1'b1});
    rx(dat);
    stop;
  endtask
endmodule // serial_host_model
